// ### rtl/drive_profile_pkg.sv
// Shared constants and carrier types for the drive profile state machine.
// Assumes a single 125 MHz clock domain and an active-low async reset.
package drive_profile_pkg;

  // ----------------------------------------
  // Object indices
  // ----------------------------------------
  localparam logic [15:0] cmd_word_idx = 16'h6040;
  localparam logic [15:0] state_word_idx = 16'h6041;
  localparam logic [15:0] err_reg_idx = 16'h1001;

  // ----------------------------------------
  // Command word bit positions
  // ----------------------------------------
  localparam int cw_so = 0;
  localparam int cw_ev = 1;
  localparam int cw_qs = 2;
  localparam int cw_eo = 3;
  localparam int cw_fr = 7;

  // ----------------------------------------
  // Status word bit positions
  // ----------------------------------------
  localparam int sw_rtso = 0;
  localparam int sw_so = 1;
  localparam int sw_oe = 2;
  localparam int sw_fault = 3;
  localparam int sw_ve = 4;
  localparam int sw_qs = 5;
  localparam int sw_sod = 6;

  // ----------------------------------------
  // Emergency message layout
  // ----------------------------------------
  localparam logic [15:0] emcy_code = 16'hff00;
  localparam logic [7:0] emcy_reserved = 8'h00;
  localparam int emcy_bytes = 8;

  // ----------------------------------------
  // Timing counts
  // ----------------------------------------
  localparam int clk_mhz = 125;
  localparam int init_time_us = 10;
  localparam int init_cycles = init_time_us * clk_mhz;
  localparam int fault_react_us = 4;
  localparam int fault_react_cycles = fault_react_us * clk_mhz;
  localparam int free_cycle_us = 20;
  localparam int free_cycle_cycles = free_cycle_us * clk_mhz;
  localparam int cnt_w = 16;

  // ----------------------------------------
  // Sync modes and states
  // ----------------------------------------
  localparam logic sync_free_run = 1'b0;
  localparam logic sync_dc = 1'b1;

  typedef enum logic [2:0] {
    st_not_ready,
    st_sw_on_disabled,
    st_ready,
    st_switched_on,
    st_op_enabled,
    st_quick_stop,
    st_fault_react,
    st_fault
  } drive_state_e;

  typedef struct packed {
    logic [15:0] alarm_code;
    logic [7:0] err_reg;
  } alarm_info_s;

  typedef struct packed {
    logic [7:0] byte7;
    logic [7:0] byte6;
    logic [7:0] byte5;
    logic [7:0] byte4;
    logic [7:0] byte3;
    logic [7:0] byte2;
    logic [7:0] byte1;
    logic [7:0] byte0;
  } emcy_msg_s;

endpackage

// ### rtl/drive_profile_state_machine.sv
// Drive power state machine, sync mode selection and emergency message.
// Assumes command word and sync setting come from same-clock fieldbus logic;
// sync0 and servo alarm arrive asynchronously from outside.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// RL1: Two sync modes, free-run or distributed clock, picked by sync control.
// RL2: Free-run mode paces processing from an internal cycle counter.
// RL3: DC mode paces processing from each Sync0 event.
// RL4: Application timing derives from Sync0 of the shared reference clock.
// RL5: Servo alarm queues an emergency message toward the mailbox.
// RL6: Message is 8 bytes: code FF00, error register, alarm code, reserved.
// RL7: After reset stay not-ready during init, then go switch-on-disabled.
// RL8: Switch-on-disabled keeps main power off.
// RL9: Ready permits main power, drive function disabled.
// RL10: Switched-on has main power applied, drive function disabled.
// RL11: Operation enabled turns drive function and servo on.
// RL12: Quick stop command in operation enabled enters quick-stop-active, running quick stop.
// RL13: Alarm enters fault reaction, then settles in fault with alarm held; an alarm rising in not-ready only queues the message.
// RL14: Command word bits decode shutdown, switch on, enable, disable, reset.
// RL15: Status bits 6,5,3,2,1,0 encode state; bit 4 unspecified.
// RL16: Reset returns to not-ready and clears command bit 7 history.
module drive_profile_state_machine (
  input wire logic clk, // 125 MHz clock
  input wire logic nrst, // Async reset, active low
  input wire logic [15:0] drive_command_word, // Command word, same clock
  input wire logic sync_mode, // Sync control: 0 free-run, 1 DC
  input wire logic sync0_in, // Sync0 event pin, async
  input wire logic servo_alarm_in, // Servo alarm level, async
  input wire logic [15:0] alarm_code, // Servo alarm code
  input wire logic [7:0] error_register, // Error register contents
  input wire logic emcy_ready, // Mailbox takes the message
  output logic [15:0] drive_state_report_word, // Status word
  output logic proc_tick, // Processing cycle pulse
  output logic main_power_en, // Main power allowed on
  output logic drive_en, // Drive function and servo on
  output logic quick_stop_run, // Quick stop function active
  output logic fault_react_run, // Alarm handling sequence active
  output logic alarm_active, // Alarm held in fault reaction or fault
  output logic emcy_valid, // Emergency message pending
  output logic [63:0] emcy_data // Emergency message bytes 0..7
);

  typedef struct packed {
    drive_profile_pkg::drive_state_e st;
    logic [15:0] cnt;
    logic [15:0] tick_cnt;
    logic fr_prev;
    logic [2:0] sync0_sy;
    logic sync0_prev;
    logic [2:0] alarm_sy;
    logic alarm_lvl;
    logic tick;
    logic emcy_v;
    drive_profile_pkg::emcy_msg_s emcy;
    logic [15:0] sw;
  } state_s;

  state_s s_r;
  state_s s_nxt;

  // ----------------------------------------
  // Status word encoding
  // ----------------------------------------
  function automatic logic [15:0] status_of(
    input drive_profile_pkg::drive_state_e st
  );
    logic [15:0] w;
    w = 16'h0000;
    case (st)
      drive_profile_pkg::st_not_ready: begin
        w = 16'h0000;
      end
      drive_profile_pkg::st_sw_on_disabled: begin
        w[drive_profile_pkg::sw_sod] = 1'b1;
        w[drive_profile_pkg::sw_qs] = 1'b1;
      end
      drive_profile_pkg::st_ready: begin
        w[drive_profile_pkg::sw_qs] = 1'b1;
        w[drive_profile_pkg::sw_rtso] = 1'b1;
      end
      drive_profile_pkg::st_switched_on: begin
        w[drive_profile_pkg::sw_qs] = 1'b1;
        w[drive_profile_pkg::sw_so] = 1'b1;
        w[drive_profile_pkg::sw_rtso] = 1'b1;
      end
      drive_profile_pkg::st_op_enabled: begin
        w[drive_profile_pkg::sw_qs] = 1'b1;
        w[drive_profile_pkg::sw_oe] = 1'b1;
        w[drive_profile_pkg::sw_so] = 1'b1;
        w[drive_profile_pkg::sw_rtso] = 1'b1;
      end
      drive_profile_pkg::st_quick_stop: begin
        // Quick stop bit low while quick stop runs
        w[drive_profile_pkg::sw_oe] = 1'b1;
        w[drive_profile_pkg::sw_so] = 1'b1;
        w[drive_profile_pkg::sw_rtso] = 1'b1;
      end
      drive_profile_pkg::st_fault_react: begin
        w[drive_profile_pkg::sw_qs] = 1'b1;
        w[drive_profile_pkg::sw_fault] = 1'b1;
        w[drive_profile_pkg::sw_oe] = 1'b1;
        w[drive_profile_pkg::sw_so] = 1'b1;
        w[drive_profile_pkg::sw_rtso] = 1'b1;
      end
      default: begin
        w[drive_profile_pkg::sw_qs] = 1'b1;
        w[drive_profile_pkg::sw_fault] = 1'b1;
      end
    endcase
    // Voltage enabled reported from main power state
    if (st == drive_profile_pkg::st_switched_on ||
        st == drive_profile_pkg::st_op_enabled ||
        st == drive_profile_pkg::st_quick_stop ||
        st == drive_profile_pkg::st_fault_react) begin
      w[drive_profile_pkg::sw_ve] = 1'b1;
    end
    return w;
  endfunction

  logic cw_disable_v;
  logic cw_quick_stop;
  logic cw_shutdown;
  logic cw_switch_on;
  logic cw_enable_op;
  logic cw_fault_reset;
  logic alarm_new;
  logic sync0_rise;

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  always_comb begin
    cw_disable_v = ~drive_command_word[drive_profile_pkg::cw_ev]; // RL14
    cw_quick_stop = drive_command_word[drive_profile_pkg::cw_ev] &
      ~drive_command_word[drive_profile_pkg::cw_qs]; // RL14
    cw_shutdown = drive_command_word[2:0] == 3'b110; // RL14
    cw_switch_on = drive_command_word[3:0] == 4'b0111; // RL14
    cw_enable_op = drive_command_word[3:0] == 4'b1111; // RL14
    cw_fault_reset = drive_command_word[drive_profile_pkg::cw_fr] &
      ~s_r.fr_prev; // RL14
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.fr_prev = drive_command_word[drive_profile_pkg::cw_fr];
    // Stage one feeds only stage two of each synchroniser
    s_nxt.sync0_sy = {s_r.sync0_sy[1:0], sync0_in};
    s_nxt.alarm_sy = {s_r.alarm_sy[1:0], servo_alarm_in};
    // Level changes once second and third stages agree
    if (s_r.sync0_sy[2] == s_r.sync0_sy[1]) begin
      s_nxt.sync0_prev = s_r.sync0_sy[2];
    end
    if (s_r.alarm_sy[2] == s_r.alarm_sy[1]) begin
      s_nxt.alarm_lvl = s_r.alarm_sy[2];
    end
    sync0_rise = s_r.sync0_sy[2] & s_r.sync0_sy[1] & ~s_r.sync0_prev;
    alarm_new = s_r.alarm_sy[2] & s_r.alarm_sy[1] & ~s_r.alarm_lvl;

    // Processing cycle pacing
    s_nxt.tick = 1'b0;
    if (sync_mode == drive_profile_pkg::sync_dc) begin
      s_nxt.tick_cnt = 16'h0000;
      s_nxt.tick = sync0_rise; // RL3 RL4
    end else if (s_r.tick_cnt ==
                 16'(drive_profile_pkg::free_cycle_cycles - 1)) begin
      s_nxt.tick_cnt = 16'h0000; // RL1
      s_nxt.tick = 1'b1; // RL2
    end else begin
      s_nxt.tick_cnt = s_r.tick_cnt + 16'h0001; // RL2
    end

    // Emergency message queue; new alarm wins over handshake
    if (s_r.emcy_v && emcy_ready) begin
      s_nxt.emcy_v = 1'b0;
    end
    if (alarm_new) begin
      s_nxt.emcy_v = 1'b1; // RL5
      s_nxt.emcy.byte0 = drive_profile_pkg::emcy_code[7:0]; // RL6
      s_nxt.emcy.byte1 = drive_profile_pkg::emcy_code[15:8]; // RL6
      s_nxt.emcy.byte2 = error_register; // RL6
      s_nxt.emcy.byte3 = drive_profile_pkg::emcy_reserved; // RL6
      s_nxt.emcy.byte4 = alarm_code[7:0]; // RL6
      s_nxt.emcy.byte5 = alarm_code[15:8]; // RL6
      s_nxt.emcy.byte6 = drive_profile_pkg::emcy_reserved; // RL6
      s_nxt.emcy.byte7 = drive_profile_pkg::emcy_reserved; // RL6
    end

    // Power state machine
    case (s_r.st)
      drive_profile_pkg::st_not_ready: begin
        // Commands are ignored until init completes
        if (s_r.cnt == 16'(drive_profile_pkg::init_cycles - 1)) begin
          s_nxt.st = drive_profile_pkg::st_sw_on_disabled; // RL7
          s_nxt.cnt = 16'h0000;
        end else begin
          s_nxt.cnt = s_r.cnt + 16'h0001; // RL7
        end
      end
      drive_profile_pkg::st_sw_on_disabled: begin
        if (cw_shutdown) begin
          s_nxt.st = drive_profile_pkg::st_ready; // RL14
        end
      end
      drive_profile_pkg::st_ready: begin
        if (cw_disable_v || cw_quick_stop) begin
          s_nxt.st = drive_profile_pkg::st_sw_on_disabled; // RL14
        end else if (cw_enable_op) begin
          s_nxt.st = drive_profile_pkg::st_op_enabled; // RL14
        end else if (cw_switch_on) begin
          s_nxt.st = drive_profile_pkg::st_switched_on; // RL14
        end
      end
      drive_profile_pkg::st_switched_on: begin
        if (cw_disable_v || cw_quick_stop) begin
          s_nxt.st = drive_profile_pkg::st_sw_on_disabled; // RL14
        end else if (cw_shutdown) begin
          s_nxt.st = drive_profile_pkg::st_ready; // RL14
        end else if (cw_enable_op) begin
          s_nxt.st = drive_profile_pkg::st_op_enabled; // RL14
        end
      end
      drive_profile_pkg::st_op_enabled: begin
        if (cw_disable_v) begin
          s_nxt.st = drive_profile_pkg::st_sw_on_disabled; // RL14
        end else if (cw_quick_stop) begin
          s_nxt.st = drive_profile_pkg::st_quick_stop; // RL12
        end else if (cw_shutdown) begin
          s_nxt.st = drive_profile_pkg::st_ready; // RL14
        end else if (cw_switch_on) begin
          s_nxt.st = drive_profile_pkg::st_switched_on; // RL14
        end
      end
      drive_profile_pkg::st_quick_stop: begin
        if (cw_disable_v) begin
          s_nxt.st = drive_profile_pkg::st_sw_on_disabled; // RL14
        end else if (cw_enable_op) begin
          s_nxt.st = drive_profile_pkg::st_op_enabled; // RL14
        end
      end
      drive_profile_pkg::st_fault_react: begin
        // Commands ignored while the alarm sequence runs
        if (s_r.cnt == 16'(drive_profile_pkg::fault_react_cycles - 1)) begin
          s_nxt.st = drive_profile_pkg::st_fault; // RL13
          s_nxt.cnt = 16'h0000;
        end else begin
          s_nxt.cnt = s_r.cnt + 16'h0001; // RL13
        end
      end
      default: begin
        // Fault reset needs a fresh bit 7 edge and a cleared alarm
        if (cw_fault_reset && !s_r.alarm_lvl) begin
          s_nxt.st = drive_profile_pkg::st_sw_on_disabled; // RL14
        end
      end
    endcase
    // Alarm overrides any command outside the fault states and not-ready
    if (alarm_new && s_r.st != drive_profile_pkg::st_fault &&
        s_r.st != drive_profile_pkg::st_fault_react &&
        s_r.st != drive_profile_pkg::st_not_ready) begin
      s_nxt.st = drive_profile_pkg::st_fault_react; // RL13
      s_nxt.cnt = 16'h0000;
    end
    s_nxt.sw = status_of(s_nxt.st); // RL15
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0; // RL16
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign drive_state_report_word = s_r.sw;
  assign proc_tick = s_r.tick;
  // Power and drive enables decode the registered state
  assign main_power_en = s_r.st == drive_profile_pkg::st_ready ||
    s_r.st == drive_profile_pkg::st_switched_on ||
    s_r.st == drive_profile_pkg::st_op_enabled ||
    s_r.st == drive_profile_pkg::st_quick_stop ||
    s_r.st == drive_profile_pkg::st_fault_react; // RL8 RL9 RL10
  assign drive_en = s_r.st == drive_profile_pkg::st_op_enabled; // RL11
  assign quick_stop_run = s_r.st == drive_profile_pkg::st_quick_stop; // RL12
  assign fault_react_run = s_r.st == drive_profile_pkg::st_fault_react; // RL13
  assign alarm_active = s_r.st == drive_profile_pkg::st_fault ||
    s_r.st == drive_profile_pkg::st_fault_react; // RL13
  assign emcy_valid = s_r.emcy_v;
  assign emcy_data = s_r.emcy;

endmodule

`default_nettype wire

// ### testbench/drive_profile_state_machine_chk.sv
// Checker for the drive profile state machine ports.
// Assumes one clock domain; bound into the design top module.
`timescale 1ns/1ps
`default_nettype none
module drive_profile_state_machine_chk (
  input wire logic clk, // Clock
  input wire logic nrst, // Reset, active low
  input wire logic [15:0] drive_command_word, // Command word
  input wire logic sync_mode, // Sync mode
  input wire logic sync0_in, // Sync0 event
  input wire logic servo_alarm_in, // Servo alarm
  input wire logic emcy_ready, // Mailbox ready
  input wire logic [15:0] drive_state_report_word, // Status word
  input wire logic proc_tick, // Processing tick
  input wire logic main_power_en, // Main power
  input wire logic drive_en, // Drive on
  input wire logic quick_stop_run, // Quick stop
  input wire logic fault_react_run, // Fault reaction
  input wire logic alarm_active, // Alarm held
  input wire logic emcy_valid, // Message pending
  input wire logic [63:0] emcy_data // Message bytes
);
  logic [6:0] st;
  assign st = drive_state_report_word[6:0];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ----------------------------------------
  // State outputs
  // ----------------------------------------
  a_off_no_power: assert property (
    st == 7'h60 |-> !main_power_en && !drive_en) else $error("power in off");
  a_ready_power: assert property (
    st == 7'h21 |-> main_power_en && !drive_en) else $error("ready outputs");
  a_switched_on: assert property (
    st == 7'h33 |-> main_power_en && !drive_en) else $error("on outputs");
  a_drive_state: assert property (
    drive_en |-> st == 7'h37 && main_power_en) else $error("drive state");
  a_quick_stop: assert property (
    quick_stop_run |-> st == 7'h17 && !drive_en) else $error("quick stop");
  a_fault_react: assert property (
    fault_react_run |-> alarm_active && st == 7'h3f) else $error("reaction");
  a_fault_settle: assert property (
    $fell(fault_react_run) |-> alarm_active && st == 7'h28)
    else $error("fault state");
  a_enable_cmd: assert property (
    st == 7'h21 && drive_command_word[3:0] == 4'hf && !servo_alarm_in
    |=> drive_en) else $error("enable from ready");
  // ----------------------------------------
  // Emergency message and sync
  // ----------------------------------------
  a_emcy_queue: assert property (
    $rose(alarm_active) |-> emcy_valid) else $error("message not queued");
  a_emcy_hold: assert property (
    emcy_valid && !emcy_ready |=> emcy_valid) else $error("message lost");
  a_emcy_format: assert property (
    emcy_valid |-> emcy_data[31:0] == {8'h00, emcy_data[23:16], 16'hff00}
    && emcy_data[63:48] == 16'h0000) else $error("message layout");
  a_dc_tick: assert property (
    sync_mode && $rose(sync0_in) |-> ##[2:6] proc_tick)
    else $error("no tick on sync0");
  c_drive: cover property (drive_en);
  c_quick: cover property (quick_stop_run);
  c_fault: cover property (alarm_active && !fault_react_run);
  c_mailbox: cover property (emcy_valid && emcy_ready);
endmodule
bind drive_profile_state_machine drive_profile_state_machine_chk chk (
  .clk(clk), .nrst(nrst), .drive_command_word(drive_command_word),
  .sync_mode(sync_mode), .sync0_in(sync0_in),
  .servo_alarm_in(servo_alarm_in), .emcy_ready(emcy_ready),
  .drive_state_report_word(drive_state_report_word),
  .proc_tick(proc_tick), .main_power_en(main_power_en),
  .drive_en(drive_en), .quick_stop_run(quick_stop_run),
  .fault_react_run(fault_react_run), .alarm_active(alarm_active),
  .emcy_valid(emcy_valid), .emcy_data(emcy_data));
`default_nettype wire

// ### testbench/drive_profile_state_machine_tb.sv
// Self-checking bench for the drive profile state machine.
// Assumes the master model and checker files are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module drive_profile_state_machine_tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [15:0] cmd_next = 16'h0000;
  logic sync_on = 1'b0;
  logic sync_mode = 1'b0;
  logic servo_alarm_in = 1'b0;
  logic [15:0] alarm_code = 16'h0000;
  logic [7:0] error_register = 8'h00;
  logic emcy_ready = 1'b0;
  wire logic [15:0] cmd_w;
  wire logic sync0_w;
  logic [15:0] status;
  logic proc_tick, main_power_en, drive_en, quick_stop_run;
  logic fault_react_run, alarm_active, emcy_valid;
  logic [63:0] emcy_data;
  int failures = 0;
  int n_tests = 0;
  always #4 clk = ~clk;
  fieldbus_master_model master (.clk(clk), .nrst(nrst), .cmd_next(cmd_next),
    .sync_on(sync_on), .drive_command_word(cmd_w), .sync0_in(sync0_w));
  drive_profile_state_machine dut (.clk(clk), .nrst(nrst),
    .drive_command_word(cmd_w), .sync_mode(sync_mode), .sync0_in(sync0_w),
    .servo_alarm_in(servo_alarm_in), .alarm_code(alarm_code),
    .error_register(error_register), .emcy_ready(emcy_ready),
    .drive_state_report_word(status), .proc_tick(proc_tick),
    .main_power_en(main_power_en), .drive_en(drive_en),
    .quick_stop_run(quick_stop_run), .fault_react_run(fault_react_run),
    .alarm_active(alarm_active), .emcy_valid(emcy_valid),
    .emcy_data(emcy_data));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmd(input logic [15:0] w, input logic [15:0] exp);
    @(posedge clk) cmd_next <= w;
    repeat (2) @(posedge clk);
    @(negedge clk) `CHK("status", exp, status)
  endtask
  task automatic do_reset();
    @(posedge clk) nrst <= 1'b0;
    cmd_next <= 16'h0000;
    repeat (20) @(posedge clk);
    @(negedge clk) `CHK("reset drive", 1'b0, drive_en)
    @(posedge clk) nrst <= 1'b1;
    repeat (1240) @(posedge clk);
    @(negedge clk) `CHK("init status", 16'h0000, status)
    repeat (20) @(posedge clk);
    @(negedge clk) `CHK("init done", 16'h0060, status)
    $display("test reset done");
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_walk();
    cmd(16'h0006, 16'h0021);
    `CHK("power ready", 1'b1, main_power_en)
    cmd(16'h000f, 16'h0037);
    `CHK("drive on", 1'b1, drive_en)
    cmd(16'h0006, 16'h0021);
    cmd(16'h0007, 16'h0033);
    `CHK("power on", 1'b1, main_power_en)
    `CHK("drive off", 1'b0, drive_en)
    cmd(16'h000f, 16'h0037);
    cmd(16'h000b, 16'h0017);
    `CHK("quick run", 1'b1, quick_stop_run)
    cmd(16'h000f, 16'h0037);
    cmd(16'h0007, 16'h0033);
    cmd(16'h0009, 16'h0060);
    cmd(16'h0000, 16'h0060);
    `CHK("power off", 1'b0, main_power_en)
    cmd(16'h0006, 16'h0021);
    cmd(16'h0002, 16'h0060);
    cmd(16'h0006, 16'h0021);
    cmd(16'h0007, 16'h0033);
    cmd(16'h0006, 16'h0021);
    cmd(16'h000f, 16'h0037);
    cmd(16'h000b, 16'h0017);
    cmd(16'h0001, 16'h0060);
    $display("test walk done");
  endtask
  task automatic t_alarm();
    int n;
    cmd(16'h0006, 16'h0021);
    @(posedge clk) servo_alarm_in <= 1'b1;
    alarm_code <= 16'h1234;
    error_register <= 8'h81;
    n = 0;
    while (emcy_valid !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    `CHK("message", 64'h0000_1234_0081_ff00, emcy_data)
    `CHK("reacting", 16'h003f, status)
    n = 0;
    while (fault_react_run === 1'b1 && n < 600) begin
      n++;
      @(negedge clk);
    end
    `CHK("reaction cycles", 500, n)
    `CHK("fault", 16'h0028, status)
    @(posedge clk) emcy_ready <= 1'b1;
    @(posedge clk) emcy_ready <= 1'b0;
    @(negedge clk) `CHK("taken", 1'b0, emcy_valid)
    cmd(16'h0080, 16'h0028);
    @(posedge clk) servo_alarm_in <= 1'b0;
    cmd(16'h0000, 16'h0028);
    cmd(16'h0080, 16'h0060);
    `CHK("alarm cleared", 1'b0, alarm_active)
    $display("test alarm done");
  endtask
  task automatic t_sync();
    int n;
    @(posedge clk) sync_mode <= 1'b0;
    n = 0;
    while (proc_tick !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (proc_tick !== 1'b1 && n < 3000);
    `CHK("free period", 2500, n)
    @(posedge clk) sync_mode <= 1'b1;
    sync_on <= 1'b1;
    n = 0;
    while (sync0_w !== 1'b1 && n < 500) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    repeat (1200) begin
      if (proc_tick === 1'b1) n++;
      @(negedge clk);
    end
    `CHK("dc ticks", 3, n)
    @(posedge clk) sync_on <= 1'b0;
    $display("test sync done");
  endtask
  task automatic t_rst2();
    cmd(16'h0006, 16'h0021);
    cmd(16'h000f, 16'h0037);
    do_reset();
  endtask
  initial begin
    repeat (50000) @(posedge clk);
    failures++;
    $display("watchdog expired");
    conclude();
  end
  initial begin
    do_reset();
    t_walk();
    t_alarm();
    t_sync();
    t_rst2();
    conclude();
  end
endmodule
`undef CHK
`default_nettype wire

// ### testbench/fieldbus_master_model.sv
// Fieldbus master model: presents the command word and Sync0 events.
// Assumes the bench sets cmd_next and sync_on on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module fieldbus_master_model #(
  parameter int sync_period = 400
) (
  input wire logic clk, // Shared clock
  input wire logic nrst, // Reset, active low
  input wire logic [15:0] cmd_next, // Command word to send
  input wire logic sync_on, // Sync0 generation on
  output logic [15:0] drive_command_word, // Command word to device
  output logic sync0_in // Sync0 event
);
  logic [15:0] sys_time_r;
  // ----------------------------------------
  // Shared system time and Sync0 pulses
  // ----------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sys_time_r <= 16'h0000;
      drive_command_word <= 16'h0000;
      sync0_in <= 1'b0;
    end else begin
      drive_command_word <= cmd_next;
      sys_time_r <= (sys_time_r == 16'(sync_period - 1)) ? 16'h0000
          : sys_time_r + 16'h0001;
      sync0_in <= sync_on && (sys_time_r < 16'h0008);
    end
  end
endmodule
`default_nettype wire
